// >>> hw/jbt_pkg.sv
// Package of constants and types for the boundary-scan test access port.
// What this block does
// [RULE1] Instruction register is exactly ten bits.
// [RULE2] Sixteen-state controller steps on rising test clock.
// [RULE3] Reset state: scan off, identification instruction current.
// [RULE4] Power-up starts in reset state, no reset pin.
// [RULE5] Five high mode-select clocks force reset state.
// [RULE6] Tester clocks 01100 to reach instruction shift.
// [RULE7] Data out floats except in both shift states.
// [RULE8] Instruction shift sends capture pattern out, falling edge.
// [RULE9] Tester raises mode-select with last opcode bit.
// [RULE10] Sample captures live pins, outputs stay functional.
// [RULE11] Data shift chains capture cells input to output.
// [RULE12] Update copies capture cells into update cells.
// [RULE13] Two high clocks from shift reach update.
// [RULE14] Enable capture samples core even when pins float.
// [RULE15] External test drives pins from update cells.
// [RULE16] All-ones selects bypass, one-cycle path.
// [RULE17] Identification loads 32-bit code and shifts it.
// [RULE18] User code loads signature, valid after configuration.
// [RULE19] Signature comes from volatile copy, reload needed.
// [RULE20] Clamp drives pins from update cells, bypass path.
// [RULE21] High-impedance floats all pins, bypass path.
// [RULE22] Bypass register is one stage long.
// [RULE23] Each pin has three-bit cell.
// [RULE24] Enable update cell is active low.
// [RULE25] No asynchronous test reset input.
// [RULE26] Opcodes are parameters; unknown selects bypass.
// [RULE27] Registers shift least significant bit first.
package jbt_pkg;
  localparam int IR_W = 10;
  localparam int ID_W = 32;
  // Bit positions inside one pin's scan cell.
  localparam int CELL_W = 3;
  localparam int CELL_PIN = 0;
  localparam int CELL_OUT = 1;
  localparam int CELL_OEN = 2;
  localparam logic [IR_W-1:0] OP_SAMPLE = 10'h005;
  localparam logic [IR_W-1:0] OP_EXTEST = 10'h00F;
  localparam logic [IR_W-1:0] OP_BYPASS = 10'h3FF;
  localparam logic [IR_W-1:0] OP_IDCODE = 10'h006;
  localparam logic [IR_W-1:0] OP_USERCODE = 10'h007;
  localparam logic [IR_W-1:0] OP_CLAMP = 10'h00A;
  localparam logic [IR_W-1:0] OP_HIGHZ = 10'h00B;
  localparam logic [IR_W-1:0] IR_CAPTURE = 10'h155;
  // Arbitrary neutral identification value.
  localparam logic [ID_W-1:0] ID_VALUE = 32'h0000_0001;
  typedef enum logic [15:0] {
    ST_RESET = 16'h0001, ST_IDLE = 16'h0002, ST_SEL_DR = 16'h0004, ST_CAP_DR = 16'h0008,
    ST_SH_DR = 16'h0010, ST_EX1_DR = 16'h0020, ST_PA_DR = 16'h0040, ST_EX2_DR = 16'h0080,
    ST_UP_DR = 16'h0100, ST_SEL_IR = 16'h0200, ST_CAP_IR = 16'h0400, ST_SH_IR = 16'h0800,
    ST_EX1_IR = 16'h1000, ST_PA_IR = 16'h2000, ST_EX2_IR = 16'h4000, ST_UP_IR = 16'h8000
  } jbt_state_e;
  typedef struct packed {
    logic out_value;
    logic out_enable_n;
  } jbt_pad_s;
endpackage

// >>> hw/jbt_tap.sv
// Boundary-scan test access port with per-pin scan cells.
`timescale 1ns/10ps
`default_nettype none
module jbt_tap
#(
  parameter int NPINS = 4,
  parameter logic [jbt_pkg::IR_W-1:0] OP_SAMPLE = jbt_pkg::OP_SAMPLE,
  parameter logic [jbt_pkg::IR_W-1:0] OP_EXTEST = jbt_pkg::OP_EXTEST,
  parameter logic [jbt_pkg::IR_W-1:0] OP_IDCODE = jbt_pkg::OP_IDCODE,
  parameter logic [jbt_pkg::IR_W-1:0] OP_USERCODE = jbt_pkg::OP_USERCODE,
  parameter logic [jbt_pkg::IR_W-1:0] OP_CLAMP = jbt_pkg::OP_CLAMP,
  parameter logic [jbt_pkg::IR_W-1:0] OP_HIGHZ = jbt_pkg::OP_HIGHZ
)
(
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic tck_in,
  input wire logic tms_in,
  input wire logic tdi_in,
  output logic tdo_out,
  output logic tdo_oe_n_out,
  input wire logic global_output_enable_pin_in,
  input wire logic [NPINS-1:0] core_output_value_in,
  input wire logic [NPINS-1:0] core_output_enable_value_in,
  input wire logic [NPINS-1:0] pad_in,
  output jbt_pkg::jbt_pad_s [NPINS-1:0] pad_out,
  input wire logic [jbt_pkg::ID_W-1:0] user_signature_in,
  input wire logic config_done_in,
  output logic scan_test_active_out
);
  import jbt_pkg::*;

  // The controller runs on the test clock; power-up reset is the system
  // reset, released through two flops, then synchronised into tck.
  typedef struct packed {
    logic [1:0] rst_sync;
  } jbt_sys_s;
  jbt_sys_s sys;
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
      sys <= '0;
    else
      sys <= '{rst_sync: {sys.rst_sync[0], 1'b1}};
  end

  logic [1:0] trst_sync;
  always_ff @(posedge tck_in or negedge nrst_in)
  begin
    if (!nrst_in)
      trst_sync <= 2'b00;
    else
      trst_sync <= {trst_sync[0], sys.rst_sync[1]};
  end
  logic rst_tck_n;
  assign rst_tck_n = trst_sync[1];

  typedef struct packed {
    jbt_state_e st;
    logic [IR_W-1:0] ir_sh;
    logic [IR_W-1:0] ir;
    logic byp;
    logic [ID_W-1:0] id_sh;
    logic [CELL_W*NPINS-1:0] bsr_cap;
    logic [CELL_W*NPINS-1:0] bsr_upd;
    logic [CELL_W*NPINS-1:0] cap_meta;
    logic [CELL_W*NPINS-1:0] cap_sync;
    logic [1:0] done_sync;
  } jbt_rise_s;

  jbt_rise_s r;
  jbt_rise_s next_r;

  logic sel_extest;
  logic sel_sample;
  logic sel_id;
  logic sel_user;
  logic sel_clamp;
  logic sel_highz;
  logic sel_bsr;
  logic sel_idreg;
  always_comb
  begin
    sel_extest = (r.ir == OP_EXTEST);
    sel_sample = (r.ir == OP_SAMPLE);
    sel_id = (r.ir == OP_IDCODE);
    sel_user = (r.ir == OP_USERCODE);
    sel_clamp = (r.ir == OP_CLAMP);
    sel_highz = (r.ir == OP_HIGHZ);
    sel_bsr = sel_extest || sel_sample;
    // Anything else, including all ones, lands on bypass. [RULE16] [RULE26]
    sel_idreg = sel_id || sel_user;
  end

  // Each pin owns one cell: pin input, output and inverted output enable. [RULE23]
  logic [CELL_W*NPINS-1:0] cap_val;
  logic [NPINS-1:0] drive_val;
  logic [NPINS-1:0] drive_oe_n;
  genvar g;
  generate
    for (g = 0; g < NPINS; g++)
    begin : g_cell
      // Enable capture takes the core value even when the global enable
      // floats the pins. [RULE10] [RULE14] [RULE15]
      assign cap_val[CELL_W*g+CELL_PIN] = pad_in[g];
      assign cap_val[CELL_W*g+CELL_OUT] = core_output_value_in[g];
      assign cap_val[CELL_W*g+CELL_OEN] = ~core_output_enable_value_in[g];
      always_comb
      begin
        if (sel_extest || sel_clamp)
        begin
          drive_val[g] = r.bsr_upd[CELL_W*g+CELL_OUT]; // [RULE15] [RULE20]
          drive_oe_n[g] = r.bsr_upd[CELL_W*g+CELL_OEN]; // [RULE24]
        end
        else if (sel_highz)
        begin
          drive_val[g] = 1'b0;
          drive_oe_n[g] = 1'b1; // [RULE21]
        end
        else
        begin
          drive_val[g] = core_output_value_in[g];
          drive_oe_n[g] = ~(core_output_enable_value_in[g] && global_output_enable_pin_in);
        end
      end
    end
  endgenerate

  always_comb
  begin
    next_r = r;
    // Pins and core signals are not timed to the test clock, so they pass two
    // flops first; capture therefore sees them two test clocks late.
    next_r.cap_meta = cap_val;
    next_r.cap_sync = r.cap_meta;
    next_r.done_sync = {r.done_sync[0], config_done_in};
    unique case (r.st) // [RULE2]
      ST_RESET:
      begin
        if (tms_in)
          next_r.st = ST_RESET; // [RULE5]
        else
          next_r.st = ST_IDLE;
      end
      ST_IDLE:
      begin
        if (tms_in)
          next_r.st = ST_SEL_DR;
        else
          next_r.st = ST_IDLE;
      end
      ST_SEL_DR:
      begin
        if (tms_in)
          next_r.st = ST_SEL_IR;
        else
          next_r.st = ST_CAP_DR;
      end
      ST_CAP_DR:
      begin
        if (tms_in)
          next_r.st = ST_EX1_DR;
        else
          next_r.st = ST_SH_DR;
      end
      ST_SH_DR:
      begin
        if (tms_in)
          next_r.st = ST_EX1_DR;
        else
          next_r.st = ST_SH_DR;
      end
      ST_EX1_DR:
      begin
        if (tms_in)
          next_r.st = ST_UP_DR; // [RULE13]
        else
          next_r.st = ST_PA_DR;
      end
      ST_PA_DR:
      begin
        if (tms_in)
          next_r.st = ST_EX2_DR;
        else
          next_r.st = ST_PA_DR;
      end
      ST_EX2_DR:
      begin
        if (tms_in)
          next_r.st = ST_UP_DR;
        else
          next_r.st = ST_SH_DR;
      end
      ST_UP_DR:
      begin
        if (tms_in)
          next_r.st = ST_SEL_DR;
        else
          next_r.st = ST_IDLE;
      end
      ST_SEL_IR:
      begin
        if (tms_in)
          next_r.st = ST_RESET;
        else
          next_r.st = ST_CAP_IR;
      end
      ST_CAP_IR:
      begin
        if (tms_in)
          next_r.st = ST_EX1_IR;
        else
          next_r.st = ST_SH_IR;
      end
      ST_SH_IR:
      begin
        if (tms_in)
          next_r.st = ST_EX1_IR;
        else
          next_r.st = ST_SH_IR; // [RULE8]
      end
      ST_EX1_IR:
      begin
        if (tms_in)
          next_r.st = ST_UP_IR;
        else
          next_r.st = ST_PA_IR;
      end
      ST_PA_IR:
      begin
        if (tms_in)
          next_r.st = ST_EX2_IR;
        else
          next_r.st = ST_PA_IR;
      end
      ST_EX2_IR:
      begin
        if (tms_in)
          next_r.st = ST_UP_IR;
        else
          next_r.st = ST_SH_IR;
      end
      ST_UP_IR:
      begin
        if (tms_in)
          next_r.st = ST_SEL_DR;
        else
          next_r.st = ST_IDLE;
      end
      default: next_r.st = ST_RESET;
    endcase
    unique case (r.st)
      ST_RESET:
      begin
        next_r.ir = OP_IDCODE; // [RULE3]
      end
      ST_CAP_IR:
      begin
        next_r.ir_sh = IR_CAPTURE;
      end
      ST_SH_IR:
      begin
        next_r.ir_sh = {tdi_in, r.ir_sh[IR_W-1:1]}; // [RULE1] [RULE27]
      end
      ST_UP_IR:
      begin
        next_r.ir = r.ir_sh;
      end
      ST_CAP_DR:
      begin
        next_r.byp = 1'b0;
        if (sel_bsr)
          next_r.bsr_cap = r.cap_sync;
        if (sel_id)
          next_r.id_sh = ID_VALUE; // [RULE17]
        else if (sel_user)
          // Volatile copy, read only once the synchronised done flag is up,
          // by which time the word stands still. [RULE18] [RULE19]
          next_r.id_sh = r.done_sync[1] ? user_signature_in : '1;
      end
      ST_SH_DR:
      begin
        next_r.byp = tdi_in; // [RULE22]
        if (sel_bsr)
          next_r.bsr_cap = {tdi_in, r.bsr_cap[CELL_W*NPINS-1:1]}; // [RULE11]
        if (sel_idreg)
          next_r.id_sh = {tdi_in, r.id_sh[ID_W-1:1]};
      end
      ST_UP_DR:
      begin
        if (sel_bsr)
          next_r.bsr_upd = r.bsr_cap; // [RULE12]
      end
      default:
      begin
      end
    endcase
    // Entering reset drops scan control at once rather than one clock later,
    // so the pins never stay under test while the state says reset.
    if (next_r.st == ST_RESET)
      next_r.ir = OP_IDCODE; // [RULE3]
  end

  // Power-up puts the controller in reset with no test reset pin. [RULE4] [RULE25]
  always_ff @(posedge tck_in or negedge rst_tck_n)
  begin
    if (!rst_tck_n)
    begin
      r.st <= ST_RESET;
      r.ir_sh <= '0;
      r.ir <= OP_IDCODE;
      r.byp <= 1'b0;
      r.id_sh <= '0;
      r.bsr_cap <= '0;
      r.bsr_upd <= '0;
      r.cap_meta <= '0;
      r.cap_sync <= '0;
      r.done_sync <= 2'b00;
    end
    else
      r <= next_r;
  end

  // Output side changes on the falling edge so the tester samples it safely.
  typedef struct packed {
    logic tdo;
    logic oe_n;
  } jbt_fall_s;
  jbt_fall_s f;
  jbt_fall_s next_f;
  always_comb
  begin
    next_f.oe_n = !(r.st == ST_SH_IR || r.st == ST_SH_DR); // [RULE7]
    if (r.st == ST_SH_IR)
      next_f.tdo = r.ir_sh[0]; // [RULE8]
    else if (sel_bsr)
      next_f.tdo = r.bsr_cap[0];
    else if (sel_idreg)
      next_f.tdo = r.id_sh[0];
    else
      next_f.tdo = r.byp; // [RULE16]
  end
  always_ff @(negedge tck_in or negedge rst_tck_n)
  begin
    if (!rst_tck_n)
      f <= '{tdo: 1'b0, oe_n: 1'b1};
    else
      f <= next_f;
  end

  assign tdo_out = f.tdo;
  assign tdo_oe_n_out = f.oe_n;
  assign scan_test_active_out = (r.st != ST_RESET) && (sel_extest || sel_clamp || sel_highz);

  always_comb
  begin
    for (int i = 0; i < NPINS; i++)
    begin
      pad_out[i].out_value = drive_val[i];
      pad_out[i].out_enable_n = drive_oe_n[i];
    end
  end
endmodule
`default_nettype wire

// >>> tb/jbt_tap_asserts.sv
// Pin-level checker for the boundary-scan test access port.
`timescale 1ns/10ps
`default_nettype none
module jbt_tap_asserts
#(
  parameter int NPINS = 4
)
(
  input wire logic nrst_in,
  input wire logic tck_in,
  input wire logic tms_in,
  input wire logic tdo_oe_n_out,
  input wire logic [NPINS-1:0] core_output_value_in,
  input wire jbt_pkg::jbt_pad_s [NPINS-1:0] pad_out,
  input wire logic scan_test_active_out
);
  import jbt_pkg::*;
  logic [NPINS-1:0] pv;
  default clocking @(posedge tck_in); endclocking
  default disable iff (!nrst_in);
  always_comb
    for (int i = 0; i < NPINS; i++)
      pv[i] = pad_out[i].out_value;
  // Five high edges reach reset from any state; the outputs are looked at one
  // edge later, once the falling edge has moved the data out enable.
  property p_reset_hold;
    tms_in [*5] |=> tdo_oe_n_out && !scan_test_active_out;
  endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("reset state not held");
  property p_ir_path;
    tms_in [*5] ##1 !tms_in ##1 tms_in [*2] ##1 !tms_in [*2] |=> !tdo_oe_n_out;
  endproperty
  a_ir_path: assert property (p_ir_path) else $error("instruction shift not reached");
  property p_dr_path;
    tms_in [*5] ##1 !tms_in ##1 tms_in ##1 !tms_in [*2] |=> !tdo_oe_n_out;
  endproperty
  a_dr_path: assert property (p_dr_path) else $error("data shift not reached");
  property p_drive_cause;
    $fell(tdo_oe_n_out) |-> !$past(tms_in);
  endproperty
  a_drive_cause: assert property (p_drive_cause) else $error("output driven outside shift");
  property p_exit_float;
    !tdo_oe_n_out && tms_in |=> tdo_oe_n_out;
  endproperty
  a_exit_float: assert property (p_exit_float) else $error("output still driven");
  property p_stay_shift;
    !tdo_oe_n_out && !tms_in |=> !tdo_oe_n_out;
  endproperty
  a_stay_shift: assert property (p_stay_shift) else $error("shift state left early");
  property p_update;
    !tdo_oe_n_out && tms_in ##1 tms_in |=> tdo_oe_n_out [*2];
  endproperty
  a_update: assert property (p_update) else $error("shift reentered after exit");
  property p_functional;
    !scan_test_active_out |-> pv == core_output_value_in;
  endproperty
  a_functional: assert property (p_functional) else $error("pad value not functional");
  c_long_shift: cover property (!tdo_oe_n_out [*8]);
  c_scan_on: cover property ($rose(scan_test_active_out));
  c_float: cover property ($rose(tdo_oe_n_out));
endmodule
bind jbt_tap jbt_tap_asserts #(.NPINS(NPINS)) i_jbt_tap_asserts (.nrst_in, .tck_in, .tms_in,
  .tdo_oe_n_out, .core_output_value_in, .pad_out, .scan_test_active_out);
`default_nettype wire

// >>> tb/jbt_tap_tb.sv
// Self-checking bench for the boundary-scan port.
`timescale 1ns/10ps
`default_nettype none
module jbt_tap_tb;
  import jbt_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic gen = 1'b1;
  logic done = 1'b0;
  logic [3:0] cv = 4'h0;
  logic [3:0] ce = 4'h0;
  logic [3:0] pi = 4'h0;
  logic [31:0] sig = 32'hA5C3_0F96;
  logic [3:0] pv;
  logic [3:0] pe;
  wire logic tck, tms, tdi, tdo, oen, act;
  jbt_pad_s [3:0] pad;
  int n_mismatch = 0;
  int check_count = 0;
  jbt_tap i_jbt_tap (.clk_sys_in(clk), .nrst_in(nrst), .tck_in(tck), .tms_in(tms),
    .tdi_in(tdi), .tdo_out(tdo), .tdo_oe_n_out(oen), .global_output_enable_pin_in(gen),
    .core_output_value_in(cv), .core_output_enable_value_in(ce), .pad_in(pi), .pad_out(pad),
    .user_signature_in(sig), .config_done_in(done), .scan_test_active_out(act));
  jbt_tester i_jbt_tester (.tck_out(tck), .tms_out(tms), .tdi_out(tdi), .tdo_in(tdo),
    .oe_n_in(oen));
  initial
    forever #5 clk = ~clk;
  always_comb
    for (int i = 0; i < 4; i++)
    begin
      pv[i] = pad[i].out_value;
      pe[i] = pad[i].out_enable_n;
    end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic t_id;
    logic [31:0] q;
    i_jbt_tester.seq(16'h001F, 5);
    i_jbt_tester.seq(16'h0000, 1);
    i_jbt_tester.dr(32'h0, 32, q);
    chk("idcode", ID_VALUE, q);
  endtask
  task automatic t_byp;
    logic [9:0] c[4] = '{OP_BYPASS, 10'h2A3, OP_CLAMP, OP_HIGHZ};
    logic [9:0] q;
    logic [31:0] d;
    foreach (c[k])
    begin
      i_jbt_tester.seq(16'h001F, 5);
      i_jbt_tester.seq(16'h0000, 1);
      i_jbt_tester.ir(c[k], q);
      chk("ir capture", 32'(IR_CAPTURE), 32'(q));
      i_jbt_tester.dr(32'h0000_00B5, 9, d);
      chk("bypass", 32'hFFFF_FF6A, d);
      chk("active", 32'(k > 1), 32'(act));
      if (k == 2)
        chk("clamp enable", 32'h0, 32'(pe));
    end
    chk("highz", 32'hF, 32'(pe));
  endtask
  task automatic t_user;
    logic [9:0] q;
    logic [31:0] d;
    for (int c = 0; c < 2; c++)
    begin
      @(posedge clk) done <= c[0];
      i_jbt_tester.ir(OP_USERCODE, q);
      i_jbt_tester.dr(32'h0, 32, d);
      chk("usercode", c ? sig : 32'hFFFF_FFFF, d);
    end
  endtask
  task automatic t_scan;
    logic [9:0] q;
    logic [31:0] d;
    @(posedge clk)
    begin
      cv <= 4'h6;
      ce <= 4'h3;
      pi <= 4'h9;
      gen <= 1'b0;
    end
    i_jbt_tester.ir(OP_SAMPLE, q);
    chk("sample pads", 32'h6, 32'(pv));
    chk("sample enable", 32'hF, 32'(pe));
    i_jbt_tester.dr(32'h0000_0C5A, 12, d);
    chk("capture", 32'hFFFF_FB91, d);
    i_jbt_tester.ir(OP_EXTEST, q);
    chk("extest value", 32'hB, 32'(pv));
    chk("extest enable", 32'h8, 32'(pe));
    i_jbt_tester.dr(32'h0000_0249, 12, d);
    chk("pin capture", 32'h201, d & 32'h0000_0249);
    chk("new value", 32'h0, 32'(pv));
    chk("new enable", 32'h0, 32'(pe));
    i_jbt_tester.seq(16'h001F, 5);
    chk("reset active", 32'h0, 32'(act));
    chk("reset pads", 32'h6, 32'(pv));
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    t_id;
    $display("idcode test done");
    t_byp;
    $display("bypass test done");
    t_user;
    $display("usercode test done");
    t_scan;
    $display("scan test done");
    end_sim;
  end
endmodule
`default_nettype wire

// >>> tb/jbt_tester.sv
// Tester model: test clock runs only while a bit is being moved.
`timescale 1ns/10ps
`default_nettype none
module jbt_tester
(
  output logic tck_out,
  output logic tms_out,
  output logic tdi_out,
  input wire logic tdo_in,
  input wire logic oe_n_in
);
  initial
  begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b1;
  end
  task automatic tick(input logic m, input logic d, output logic q);
    tms_out = m;
    tdi_out = d;
    #23;
    q = oe_n_in ? 1'bx : tdo_in;
    #1 tck_out = 1'b1;
    #24 tck_out = 1'b0;
  endtask
  task automatic seq(input logic [15:0] m, input int n);
    logic q;
    for (int i = 0; i < n; i++)
      tick(m[i], 1'b1, q);
  endtask
  task automatic scan(input logic [31:0] d, input int n, output logic [31:0] q);
    q = '1;
    for (int i = 0; i < n; i++)
      tick(i == n - 1, d[i], q[i]);
    seq(16'h0001, 2);
  endtask
  task automatic ir(input logic [9:0] op, output logic [9:0] q);
    logic [31:0] w;
    seq(16'h0003, 4);
    scan({22'h0, op}, 10, w);
    q = w[9:0];
  endtask
  task automatic dr(input logic [31:0] d, input int n, output logic [31:0] q);
    seq(16'h0001, 3);
    scan(d, n, q);
  endtask
endmodule
`default_nettype wire
